// File: ets_pkg.sv
package ets_pkg;
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned CNT_W           = 16;
  localparam logic [15:0] CNT_MAX         = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO        = 16'h0000;
  // Tick periods in ns, per switch column
  localparam int unsigned TICK0_NS        = 100;
  localparam int unsigned TICK1_NS        = 1000;
  localparam int unsigned TICK2_NS        = 10000;
  localparam int unsigned TICK3_NS        = 100000;
  localparam int unsigned TICK4_NS        = 1000000;
  localparam int unsigned CLK_NS          = 1000 / CLK_MHZ;
  localparam int unsigned TICK0_CYC       = TICK0_NS / CLK_NS;
  localparam int unsigned TICK1_CYC       = TICK1_NS / CLK_NS;
  localparam int unsigned TICK2_CYC       = TICK2_NS / CLK_NS;
  localparam int unsigned TICK3_CYC       = TICK3_NS / CLK_NS;
  localparam int unsigned TICK4_CYC       = TICK4_NS / CLK_NS;
  localparam int unsigned PRE_W           = 18;
  // Long trigger: more than 1.6 us active
  localparam int unsigned LONG_NS         = 1600;
  localparam int unsigned LONG_CYC        = (LONG_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LEN_W           = 10;
  localparam logic [1:0]  DISP_RAW        = 2'h0;
  localparam logic [1:0]  DISP_ABS        = 2'h1;
  localparam logic [1:0]  DISP_REL        = 2'h2;
  localparam logic [3:0]  POS_GATE_FIRST  = 4'h5;
  localparam logic [3:0]  POS_TOG_FIRST   = 4'hA;
  localparam logic [3:0]  POS_EVENT       = 4'hF;
  localparam logic [2:0]  COL_LAST        = 3'h4;
  // Synchronised pin bits, at the low end of the pin vector
  localparam int unsigned SYN_STROBE      = 0;
  localparam int unsigned SYN_ZERO        = 1;
  localparam int unsigned SYN_LOW         = 2;
  localparam int unsigned SYN_HIGH        = 3;
  localparam int unsigned SYN_MON         = 4;
  localparam int unsigned SYN_W           = 5;
  localparam int unsigned PIN_W           = CNT_W + SYN_W;
  // Low-active direct input idles high
  localparam logic [PIN_W-1:0] PIN_IDLE   = {CNT_ZERO, 5'h04};
  typedef enum logic [1:0]
  {
    MODE_RESET  = 2'b00,
    MODE_GATE   = 2'b01,
    MODE_TOGGLE = 2'b10,
    MODE_EVENT  = 2'b11
  } ets_mode_type;
endpackage

// File: ets_counter.sv
`timescale 1ns/1ns
module ets_counter
  import ets_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              resetn_i,
  input  wire logic              clk_en_i,
  input  wire logic [3:0]        mode_switch_i,
  input  wire logic [1:0]        display_sel_i,
  input  wire logic              count_trigger_i,
  input  wire logic              direct_trigger_i,
  input  wire logic              count_trigger_low_input_i,
  input  wire logic              direct_sel_i,
  input  wire logic              manual_zero_i,
  input  wire logic              trace_strobe_i,
  input  wire logic [CNT_W-1:0]  analyzer_port_i,
  output logic [CNT_W-1:0]       trace_listing_o,
  output logic                   trace_valid_o,
  output logic [CNT_W-1:0]       monitor_count_o,
  output logic                   overflow_o
);
  // Pins, button and port are asynchronous to the core clock
  logic [PIN_W-1:0]  pin_raw;
  logic [PIN_W-1:0]  pin_s2;
  logic [CNT_W-1:0]  port_s2;
  logic              trig_q;
  logic [PRE_W-1:0]  pre_cnt;
  logic [LEN_W-1:0]  len_cnt;
  logic              run_tog;
  logic [CNT_W-1:0]  count;
  logic [CNT_W-1:0]  last_stamp;
  logic              first_rel;

  // Next values, one group per always_ff
  logic              next_trig_q;
  logic [PRE_W-1:0]  next_pre_cnt;
  logic [LEN_W-1:0]  next_len_cnt;
  logic              next_run_tog;
  logic [CNT_W-1:0]  next_count;
  logic              next_overflow;
  logic [CNT_W-1:0]  next_monitor_count;
  logic [CNT_W-1:0]  next_last_stamp;
  logic              next_first_rel;
  logic [CNT_W-1:0]  next_trace_listing;
  logic              next_trace_valid;

  // Decoded every cycle
  logic              trig;
  logic              zero_btn;
  logic              strobe;
  logic              tick;
  logic              advance;
  logic              long_pulse;
  logic [2:0]        col;
  logic [PRE_W-1:0]  pre_top;
  ets_mode_type      mode;

  assign pin_raw = {analyzer_port_i, count_trigger_i, direct_trigger_i,
                    count_trigger_low_input_i, manual_zero_i, trace_strobe_i};

  // One two-stage synchroniser per pin bit; only the second stage is read
  generate
    for (genvar b = 0; b < PIN_W; b++)
    begin : g_pin_sync
      logic stage1;
      logic stage2;
      logic next_stage1;
      logic next_stage2;

      always_comb
      begin
        next_stage1 = pin_raw[b];
        next_stage2 = stage1;
      end

      // Reset to the idle level so no false trigger edge follows reset
      always_ff @(posedge core_clk_i)
      begin
        if (!resetn_i)
        begin
          stage1 <= PIN_IDLE[b];
          stage2 <= PIN_IDLE[b];
        end
        else if (clk_en_i)
        begin
          stage1 <= next_stage1;
          stage2 <= next_stage2;
        end
      end

      assign pin_s2[b] = stage2;
    end
  endgenerate

  // Trigger source and synchronised pins
  always_comb
  begin
    if (direct_sel_i)
      trig = pin_s2[SYN_HIGH] | ~pin_s2[SYN_LOW];
    else
      trig = pin_s2[SYN_MON];
    zero_btn = pin_s2[SYN_ZERO];
    strobe   = pin_s2[SYN_STROBE];
    port_s2  = pin_s2[PIN_W-1:SYN_W];
  end

  // Switch position to counting mode and period column
  always_comb
  begin
    if (mode_switch_i == POS_EVENT)
    begin
      mode = MODE_EVENT;
      col  = 3'h0;
    end
    else if (mode_switch_i >= POS_TOG_FIRST)
    begin
      mode = MODE_TOGGLE;
      col  = 3'(mode_switch_i - POS_TOG_FIRST);
    end
    else if (mode_switch_i >= POS_GATE_FIRST)
    begin
      mode = MODE_GATE;
      col  = 3'(mode_switch_i - POS_GATE_FIRST);
    end
    else
    begin
      mode = MODE_RESET;
      col  = mode_switch_i[2:0];
    end
  end

  // Period column to prescaler top
  always_comb
  begin
    case (col)
      3'h0:    pre_top = PRE_W'(TICK0_CYC - 1);
      3'h1:    pre_top = PRE_W'(TICK1_CYC - 1);
      3'h2:    pre_top = PRE_W'(TICK2_CYC - 1);
      3'h3:    pre_top = PRE_W'(TICK3_CYC - 1);
      default: pre_top = PRE_W'(TICK4_CYC - 1);
    endcase
  end

  // Prescaler free-runs, so a timed count is only known to within one tick
  always_comb
  begin
    tick         = (pre_cnt >= pre_top);
    next_pre_cnt = tick ? '0 : pre_cnt + 1'b1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
      pre_cnt <= '0;
    else if (clk_en_i)
      pre_cnt <= next_pre_cnt;
  end

  // Trigger history: edge, pulse length and the toggle run flag
  always_comb
  begin
    next_trig_q = trig;
    // Length counter saturates so a held trigger cannot wrap back to short
    if (!trig)
      next_len_cnt = '0;
    else if (len_cnt <= LEN_W'(LONG_CYC))
      next_len_cnt = len_cnt + 1'b1;
    else
      next_len_cnt = len_cnt;
    long_pulse   = (len_cnt > LEN_W'(LONG_CYC));
    next_run_tog = run_tog;
    // Short pulses act on release, once their length is known
    if (mode == MODE_TOGGLE && trig_q && !trig && !long_pulse)
      next_run_tog = ~run_tog;
    if (mode == MODE_TOGGLE && trig && long_pulse)
      next_run_tog = 1'b0;
    if (mode == MODE_TOGGLE && zero_btn)
      next_run_tog = 1'b0;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      trig_q  <= 1'b0;
      len_cnt <= '0;
      run_tog <= 1'b0;
    end
    else if (clk_en_i)
    begin
      trig_q  <= next_trig_q;
      len_cnt <= next_len_cnt;
      run_tog <= next_run_tog;
    end
  end

  // Counter, sticky overflow and the copy offered to the event monitor
  always_comb
  begin
    case (mode)
      MODE_RESET:  advance = tick;
      MODE_GATE:   advance = tick & trig;
      MODE_TOGGLE: advance = tick & run_tog;
      MODE_EVENT:  advance = trig & ~trig_q;
      default:     advance = 1'b0;
    endcase
    // Wrap is the carry out of the sixteen-bit add dropping off
    next_count    = advance ? count + 1'b1 : count;
    next_overflow = overflow_o | (advance && count == CNT_MAX);
    if (mode == MODE_RESET && trig)
      next_count = CNT_ZERO;
    if (mode == MODE_TOGGLE && trig && long_pulse)
      next_count = CNT_ZERO;
    // Manual zero wins over counting and also clears the sticky flag
    if (zero_btn)
    begin
      next_count    = CNT_ZERO;
      next_overflow = 1'b0;
    end
    next_monitor_count = next_count;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      count           <= CNT_ZERO;
      overflow_o      <= 1'b0;
      monitor_count_o <= CNT_ZERO;
    end
    else if (clk_en_i)
    begin
      count           <= next_count;
      overflow_o      <= next_overflow;
      monitor_count_o <= next_monitor_count;
    end
  end

  // Trace entries; the relative form keeps the last stamp to subtract
  always_comb
  begin
    next_last_stamp    = last_stamp;
    next_first_rel     = first_rel;
    next_trace_listing = trace_listing_o;
    next_trace_valid   = strobe;
    if (strobe)
    begin
      case (display_sel_i)
        DISP_RAW: next_trace_listing = port_s2;
        DISP_ABS: next_trace_listing = count;
        DISP_REL: next_trace_listing = first_rel ? count : count - last_stamp;
        default:  next_trace_listing = port_s2;
      endcase
      next_last_stamp = count;
      next_first_rel  = 1'b0;
    end
    // Leaving the relative form rearms the first-entry flag
    if (display_sel_i != DISP_REL)
      next_first_rel = 1'b1;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!resetn_i)
    begin
      last_stamp      <= CNT_ZERO;
      first_rel       <= 1'b1;
      trace_listing_o <= CNT_ZERO;
      trace_valid_o   <= 1'b0;
    end
    else if (clk_en_i)
    begin
      last_stamp      <= next_last_stamp;
      first_rel       <= next_first_rel;
      trace_listing_o <= next_trace_listing;
      trace_valid_o   <= next_trace_valid;
    end
  end
endmodule

// File: ets_partner.sv
`timescale 1ns/1ns
module ets_partner
(
  input  wire logic core_clk_i,
  output logic      trig_o,
  output logic      high_o,
  output logic      low_n_o
);
  initial {trig_o, high_o, low_n_o} = 3'b001;
  // Level held for the whole pulse
  // Silent between calls, as while emulation is paused
  task automatic pulse(input int src, input int n);
    @(negedge core_clk_i);
    trig_o = (src == 0);
    high_o = (src == 1);
    low_n_o = (src != 2);  // Low line idles high
    repeat (n) @(negedge core_clk_i);
    {trig_o, high_o, low_n_o} = 3'b001;
    repeat (6) @(negedge core_clk_i);
  endtask
endmodule

// File: ets_counter_chk.sv
`timescale 1ns/1ns
module ets_counter_chk
(
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire logic [3:0]  mode_switch_i,
  input wire logic [1:0]  display_sel_i,
  input wire logic        count_trigger_i,
  input wire logic        direct_trigger_i,
  input wire logic        count_trigger_low_input_i,
  input wire logic        direct_sel_i,
  input wire logic        manual_zero_i,
  input wire logic        trace_strobe_i,
  input wire logic [15:0] analyzer_port_i,
  input wire logic [15:0] trace_listing_o,
  input wire logic        trace_valid_o,
  input wire logic [15:0] monitor_count_o,
  input wire logic        overflow_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  wire        act = direct_sel_i ? (direct_trigger_i | ~count_trigger_low_input_i) : count_trigger_i;
  wire [15:0] c   = monitor_count_o;
  a_count_step: assert property ($changed(c) |-> c == $past(c) + 16'h1 || c == 16'h0)
    else $error("count jumped");
  a_wrap_flag: assert property ($rose(overflow_o) |-> $past(c) == 16'hFFFF)
    else $error("overflow without wrap");
  a_trig_zeroes: assert property ((mode_switch_i < 4'h5 && act) [*4] |-> c == 16'h0)
    else $error("trigger did not zero");
  a_button_zero: assert property (manual_zero_i [*4] |-> c == 16'h0 && !overflow_o)
    else $error("button did not clear");
  a_gate_hold: assert property ((mode_switch_i inside {[4'h5:4'h9]} && !act && !manual_zero_i) [*4]
    |=> $stable(c))
    else $error("gate counted while idle");
  a_event_edge: assert property (mode_switch_i == 4'hF && $changed(c) && c != 16'h0
    |-> $past(act, 3) && !$past(act, 4))
    else $error("event count without edge");
  a_one_entry: assert property (trace_valid_o == $past(trace_strobe_i, 3))
    else $error("entry not one per strobe");
  a_raw_form: assert property (trace_valid_o && $past(display_sel_i) == 2'h0
    |-> trace_listing_o == $past(analyzer_port_i, 3))
    else $error("raw entry wrong");
endmodule
bind ets_counter ets_counter_chk u_chk (.*);

// File: tb_ets_counter.sv
`timescale 1ns/1ns
module tb_ets_counter;
  logic        core_clk_i = 0, resetn_i = 0, clk_en_i = 1, direct_sel_i = 0;
  logic        manual_zero_i = 0, trace_strobe_i = 0, trace_valid_o, overflow_o;
  logic        count_trigger_i, direct_trigger_i, count_trigger_low_input_i;
  logic [3:0]  mode_switch_i = 4'hF;
  logic [1:0]  display_sel_i = 2'h1;
  // The bench alone feeds the analyzer port, no pod shares it
  logic [15:0] analyzer_port_i = 16'hA5C3, trace_listing_o, monitor_count_o, v;
  int          miscompares = 0, checked = 0, cyc = 0;
  ets_counter DUT (.*);
  ets_partner u_far (.core_clk_i(core_clk_i), .trig_o(count_trigger_i),
    .high_o(direct_trigger_i), .low_n_o(count_trigger_low_input_i));
  initial forever #2 core_clk_i = ~core_clk_i;
  task automatic give_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic chk(input logic [15:0] seen, exp, input string nm);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // Prescaler phase is free, so timed counts are only known to one tick
  function automatic logic [15:0] rng(input logic [15:0] lo, hi);
    return {15'h0, monitor_count_o >= lo && monitor_count_o <= hi};
  endfunction
  task automatic stamp();
    v = 'x;
    wt(1);
    trace_strobe_i = 1;
    wt(1);
    trace_strobe_i = 0;
    repeat (8) @(negedge core_clk_i) if (trace_valid_o === 1'b1) v = trace_listing_o;
  endtask
  initial
  begin
    wt(20);
    resetn_i = 1;
    wt(4);
    for (int i = 0; i < 4; i++) u_far.pulse(i % 2, 6);
    direct_sel_i = 1;
    for (int i = 0; i < 3; i++) u_far.pulse(i, 6);
    chk(monitor_count_o, 16'h0004, "events");
    stamp();
    chk(v, 16'h0004, "abs");
    display_sel_i = 2'h0;
    stamp();
    chk(v, 16'hA5C3, "raw");
    display_sel_i = 2'h3;
    stamp();
    chk(v, 16'hA5C3, "raw alt");
    display_sel_i = 2'h2;
    stamp();
    chk(v, 16'h0004, "rel first");
    u_far.pulse(2, 6);
    stamp();
    chk(v, 16'h0001, "rel diff");
    $display("test stamps done");
    manual_zero_i = 1;
    wt(5);
    chk(monitor_count_o, 16'h0000, "zero");
    {manual_zero_i, direct_sel_i, mode_switch_i} = 6'h00;
    wt(200);
    chk(rng(7, 8), 1, "tick");
    clk_en_i = 0;
    wt(100);
    chk(rng(7, 8), 1, "freeze");
    clk_en_i = 1;
    u_far.pulse(0, 60);
    chk(rng(0, 1), 1, "trig zero");
    manual_zero_i = 1;
    mode_switch_i = 4'h5;
    wt(5);
    manual_zero_i = 0;
    wt(100);
    chk(monitor_count_o, 16'h0000, "gate off");
    u_far.pulse(0, 100);
    chk(rng(3, 5), 1, "gate on");
    mode_switch_i = 4'hA;
    u_far.pulse(0, 450);
    wt(100);
    chk(monitor_count_o, 16'h0000, "long");
    u_far.pulse(0, 10);
    wt(100);
    chk(rng(3, 5), 1, "short");
    manual_zero_i = 1;
    wt(5);
    manual_zero_i = 0;
    wt(100);
    chk(monitor_count_o, 16'h0000, "halt");
    mode_switch_i = 4'h1;
    wt(600);
    chk(rng(2, 3), 1, "slow tick");
    chk({15'h0, overflow_o}, 16'h0000, "no overflow");
    $display("test modes done");
    give_verdict();
  end
endmodule
